//--- ibm_regs.svh
/*
 * register offsets, field positions, reset values for the ide bus-master
 * control block. assumes inclusion by bare name from ibm_ctrl only.
 */
// Functional notes
// - a zero-to-one write of the start bit begins bus-master operation.
// - data moves between drive and memory only while start is one.
// - writing start to zero halts and drops all transfer state.
// - clearing start mid-transfer aborts and may drop buffered drive data.
// - each channel has a status register, at 02h and at 0ah.
// - status bit 7 is read-only and tells whether only one channel may run.
// - status bit 6 is a stored read/write drive 1 dma-capable flag.
// - status bit 5 is a stored read/write drive 0 dma-capable flag.
// - command bit 3 picks direction, zero read and one write.
// - active sets on start and clears at end of table or on stop.
// - interrupt sets on a rising drive interrupt, clears on write of one.
// - error sets on a failed memory transfer, clears on write of one.
`ifndef IBM_REGS_SVH
`define IBM_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// offsets within one channel, channel stride
`define IBM_CMD_OFS     3'h0
`define IBM_STS_OFS     3'h2
`define IBM_CH_BIT      3

////////////////////////////////////////////////////////////////////////////
// command fields
`define IBM_CMD_START   0
`define IBM_CMD_DIR     3

// status fields
`define IBM_STS_ACTIVE  0
`define IBM_STS_ERR     1
`define IBM_STS_INTR    2
`define IBM_STS_D0CAP   5
`define IBM_STS_D1CAP   6
`define IBM_STS_SIMPLEX 7

// reset values
`define IBM_CMD_RST     8'h00
`define IBM_STS_RST     8'h00

`endif

//--- ibm_pkg.sv
/*
 * types shared by the ide bus-master control block.
 * assumes nothing of its surroundings.
 */
package ibm_pkg;

   // one word of the drive-to-memory stream
   typedef struct packed {
      logic [31:0] data;
      logic        last;
   } ibm_word_s;

   // channel engine state, one-hot
   typedef enum logic [1:0] {
      IBM_IDLE = 2'b01,
      IBM_RUN  = 2'b10
   } ibm_chan_e;

endpackage : ibm_pkg

//--- ibm_ctrl.sv
/*
 * two-channel ide bus-master command/status logic with a two-entry stream
 * buffer per channel. assumes an 8-bit i/o register port decoded to the
 * 16-byte bus-master window, and inputs synchronous to i_core_clk.
 */
`timescale 1ns/1ps
`include "ibm_regs.svh"

module ibm_ctrl #(
   parameter int          NCH     = 2,
   parameter logic        SIMPLEX = 1'b0
) (
   input  wire logic                     i_core_clk,
   input  wire logic                     i_resetn,
   input  wire logic                     i_ce,
   input  wire logic [3:0]               i_addr,
   input  wire logic                     i_wr,
   input  wire logic                     i_rd,
   input  wire logic [7:0]               i_wdata,
   output      logic [7:0]               o_rdata,
   input  wire logic [NCH-1:0]           i_drv_irq,
   input  wire logic [NCH-1:0]           i_xfer_err,
   input  wire logic [NCH-1:0]           i_eot_done,
   output      logic [NCH-1:0]           o_start,
   output      logic [NCH-1:0]           o_dir,
   output      logic [NCH-1:0]           o_active,
   input  wire logic [NCH-1:0]           i_src_valid,
   input  wire ibm_pkg::ibm_word_s [NCH-1:0] i_src_word,
   output      logic [NCH-1:0]           o_src_ready,
   output      logic [NCH-1:0]           o_snk_valid,
   output      ibm_pkg::ibm_word_s [NCH-1:0] o_snk_word,
   input  wire logic [NCH-1:0]           i_snk_ready
);
   import ibm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   logic rst_meta_n;
   logic rst_n;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address decode, shared by both channels
   wire [2:0] reg_ofs = i_addr[2:0];
   wire       ch_sel  = i_addr[`IBM_CH_BIT];
   wire       hit_cmd = (reg_ofs == `IBM_CMD_OFS);
   wire       hit_sts = (reg_ofs == `IBM_STS_OFS);

   logic [7:0] cmd_byte [NCH];
   logic [7:0] sts_byte [NCH];

   // unmapped offsets read as zero
   wire [7:0] rd_sel = hit_cmd ? cmd_byte[ch_sel] :
                       hit_sts ? sts_byte[ch_sel] : 8'h00;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= 8'h00;
      end else if (i_ce && i_rd) begin
         o_rdata <= rd_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-channel engine
   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         ibm_chan_e state;
         ibm_chan_e next_state;
         logic      start;
         logic      dir;
         logic      intr;
         logic      err;
         logic      d0cap;
         logic      d1cap;
         logic      irq_prev;
         logic [1:0] cnt;
         logic [1:0] next_cnt;
         ibm_word_s slot0;
         ibm_word_s slot1;

         wire sel     = (ch_sel == 1'(c));
         wire wr_cmd  = i_wr && sel && hit_cmd;
         wire wr_sts  = i_wr && sel && hit_sts;
         wire go      = wr_cmd && i_wdata[`IBM_CMD_START] && !start;
         wire stop    = wr_cmd && !i_wdata[`IBM_CMD_START];
         wire next_start = wr_cmd ? i_wdata[`IBM_CMD_START] : start;
         wire irq_rise = i_drv_irq[c] && !irq_prev;

         // stream moves only while start holds
         wire push = i_src_valid[c] && o_src_ready[c] && start;
         wire pop  = o_snk_valid[c] && i_snk_ready[c] && start;

         // command readback: start and direction, rest zero
         assign cmd_byte[c] = {4'h0, dir, 2'b00, start};
         // status byte assembly
         assign sts_byte[c] = {SIMPLEX, d1cap, d0cap, 2'b00, intr, err,
                               (state == IBM_RUN)};

         // engine: a stop discards everything, no resume
         always_comb begin
            next_state = state;
            unique case (state)
               IBM_IDLE: begin
                  if (go) next_state = IBM_RUN;
               end
               IBM_RUN: begin
                  if (stop || i_eot_done[c]) next_state = IBM_IDLE;
               end
               default: next_state = IBM_IDLE;
            endcase
         end

         // buffer fill count; a stop flushes unwritten drive data
         always_comb begin
            if (stop) begin
               next_cnt = 2'd0;
            end else begin
               next_cnt = cnt + {1'b0, push} - {1'b0, pop};
            end
         end

         // command bits, stored as written
         always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               start <= 1'b0; // command resets to zero
               dir   <= 1'b0;
            end else if (i_ce && wr_cmd) begin
               start <= i_wdata[`IBM_CMD_START];
               dir   <= i_wdata[`IBM_CMD_DIR];
            end
         end

         // engine state
         always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               state <= IBM_IDLE;
            end else if (i_ce) begin
               state <= next_state;
            end
         end

         // sticky flags: a new event beats a same-cycle clear
         always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               intr     <= 1'b0;
               err      <= 1'b0;
               irq_prev <= 1'b0;
            end else if (i_ce) begin
               irq_prev <= i_drv_irq[c];
               if (irq_rise) intr <= 1'b1;
               else if (wr_sts && i_wdata[`IBM_STS_INTR]) intr <= 1'b0;
               if (i_xfer_err[c]) err <= 1'b1;
               else if (wr_sts && i_wdata[`IBM_STS_ERR]) err <= 1'b0;
            end
         end

         // drive capability flags, plain storage
         always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               d0cap <= 1'b0;
               d1cap <= 1'b0;
            end else if (i_ce && wr_sts) begin
               d0cap <= i_wdata[`IBM_STS_D0CAP];
               d1cap <= i_wdata[`IBM_STS_D1CAP];
            end
         end

         // two-entry buffer; slot0 is always the head
         always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               slot0 <= '0;
               slot1 <= '0;
            end else if (i_ce) begin
               if (pop) begin
                  slot0 <= (push && cnt == 2'd1) ? i_src_word[c] : slot1;
                  if (push && cnt == 2'd2) slot1 <= i_src_word[c];
               end else if (push) begin
                  if (cnt == 2'd0) slot0 <= i_src_word[c];
                  else slot1 <= i_src_word[c];
               end
            end
         end

         // registered handshake outputs; ready held low while stopped
         always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               cnt            <= 2'd0;
               o_src_ready[c] <= 1'b0;
               o_snk_valid[c] <= 1'b0;
            end else if (i_ce) begin
               cnt            <= next_cnt;
               o_src_ready[c] <= next_start && (next_cnt != 2'd2);
               o_snk_valid[c] <= next_start && (next_cnt != 2'd0);
            end
         end

         // mirrored control outputs
         always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               o_start[c]  <= 1'b0;
               o_dir[c]    <= 1'b0;
               o_active[c] <= 1'b0;
            end else if (i_ce) begin
               o_start[c]  <= next_start;
               o_dir[c]    <= wr_cmd ? i_wdata[`IBM_CMD_DIR] : dir;
               o_active[c] <= (next_state == IBM_RUN);
            end
         end

         assign o_snk_word[c] = slot0; // head slot is a flop
      end
   endgenerate

endmodule : ibm_ctrl

//--- ibm_ctrl_assertions.sv
/* port assertions on ibm_ctrl, channel 0.
   assumes i_ce high whenever register strobes are checked. */
`timescale 1ns/1ps
module ibm_ctrl_assertions #(
   parameter int   NCH     = 2,
   parameter logic SIMPLEX = 1'b0
) (
   input wire logic                         i_core_clk,
   input wire logic                         i_resetn,
   input wire logic                         i_ce,
   input wire logic [3:0]                   i_addr,
   input wire logic                         i_wr,
   input wire logic                         i_rd,
   input wire logic [7:0]                   i_wdata,
   input wire logic [7:0]                   o_rdata,
   input wire logic [NCH-1:0]               i_xfer_err,
   input wire logic [NCH-1:0]               i_eot_done,
   input wire logic [NCH-1:0]               o_start,
   input wire logic [NCH-1:0]               o_dir,
   input wire logic [NCH-1:0]               o_active,
   input wire logic [NCH-1:0]               o_src_ready,
   input wire logic [NCH-1:0]               o_snk_valid,
   input wire ibm_pkg::ibm_word_s [NCH-1:0] o_snk_word,
   input wire logic [NCH-1:0]               i_snk_ready
);
   import ibm_pkg::*;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   // channel 0 register strobes
   wire wc = i_ce & i_wr & (i_addr == 4'h0);
   wire rc = i_ce & i_rd & (i_addr == 4'h0);
   wire rs = i_ce & i_rd & (i_addr == 4'h2);
   ////////////////////////////////////////////////////////////////////////
   property p_go; wc && i_wdata[0] |=> o_start[0]; endproperty
   a_go: assert property (p_go) else $error("start not set");
   property p_stop; wc && !i_wdata[0] |=> !o_start[0] && !o_active[0]
      && !o_snk_valid[0]; endproperty
   a_stop: assert property (p_stop) else $error("stop ignored");
   // one cycle of grace while the stop lands
   property p_idle; !o_start[0] && !$past(o_start[0])
      |-> !o_src_ready[0] && !o_snk_valid[0]; endproperty
   a_idle: assert property (p_idle) else $error("idle moves");
   property p_dir; wc |=> o_dir[0] == $past(i_wdata[3]); endproperty
   a_dir: assert property (p_dir) else $error("dir wrong");
   property p_eot; i_ce && i_eot_done[0] |=> !o_active[0]; endproperty
   a_eot: assert property (p_eot) else $error("active stuck");
   property p_cmd; rc |=> o_rdata == {4'h0, $past(o_dir[0]), 2'b00,
      $past(o_start[0])}; endproperty
   a_cmd: assert property (p_cmd) else $error("cmd read");
   property p_sts; rs |=> o_rdata[7] == SIMPLEX && o_rdata[4:3] == 2'b00
      && o_rdata[0] == $past(o_active[0]); endproperty
   a_sts: assert property (p_sts) else $error("status read");
   property p_err; i_ce && i_xfer_err[0] ##1 rs && !i_wr |=> o_rdata[1];
   endproperty
   a_err: assert property (p_err) else $error("error lost");
   // a stalled word must not change under the receiver
   property p_hold; o_snk_valid[0] && !i_snk_ready[0] && !wc
      |=> o_snk_valid[0] && $stable(o_snk_word[0]); endproperty
   a_hold: assert property (p_hold) else $error("word lost");
   c_go: cover property (wc && i_wdata[0]);
   c_stall: cover property (o_snk_valid[0] && !i_snk_ready[0]);
   c_eot: cover property (i_eot_done[0] && o_active[0]);
endmodule : ibm_ctrl_assertions
bind ibm_ctrl ibm_ctrl_assertions #(.NCH(NCH), .SIMPLEX(SIMPLEX)) chk_u (.*);

//--- ibm_drive_model.sv
/* drive-side word source for one channel.
   assumes ready is sampled on the rising clock edge. */
`timescale 1ns/1ps
module ibm_drive_model (
   input  wire logic          i_clk,
   input  wire logic          i_en,
   input  wire logic          i_ready,
   output logic               o_valid,
   output ibm_pkg::ibm_word_s o_word
);
   import ibm_pkg::*;
   logic [31:0] n = 32'h0000_0000;
   // off-frame data is inverted so a stale word never matches
   assign o_valid = i_en;
   assign o_word = '{data: i_en ? n : ~n, last: 1'b0};
   // advance only on an accepted word
   always_ff @(posedge i_clk) begin
      if (i_en && i_ready) begin
         n <= n + 32'h0000_0001;
      end
   end
endmodule : ibm_drive_model

//--- ibm_ctrl_bench.sv
/* self-checking bench for ibm_ctrl with two drive-side sources.
   assumes the strobe register port and stream hand-over of ibm_ctrl. */
`timescale 1ns/1ps
module ibm_ctrl_bench;
   import ibm_pkg::*;
   logic            clk = 1'b0;
   logic            rstn = 1'b0;
   logic            wr = 1'b0;
   logic            rd = 1'b0;
   logic [3:0]      addr = 4'h0;
   logic [7:0]      wdata = 8'h00;
   logic [1:0]      irq = 2'b00, err = 2'b00, end_of_table_flag = 2'b00, en = 2'b00;
   logic [1:0]      srdy = 2'b11, start, dir, act, sr, kv;
   logic [7:0]      rdata;
   wire  [1:0]      svld;
   wire  ibm_word_s [1:0] sw;
   ibm_word_s [1:0] kw;
   logic [31:0]     ex [2] = '{32'h0000_0000, 32'h0000_0000};
   logic [3:0]      ra [5] = '{4'h0, 4'h2, 4'h8, 4'hA, 4'h4};
   int              num_errors = 0;
   int              n_tests = 0;
   int              pops = 0;
   always #2.5 clk = ~clk;
   ibm_ctrl dut_u (.i_core_clk(clk), .i_resetn(rstn), .i_ce(1'b1),
      .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
      .o_rdata(rdata), .i_drv_irq(irq), .i_xfer_err(err),
      .i_eot_done(end_of_table_flag), .o_start(start), .o_dir(dir), .o_active(act),
      .i_src_valid(svld), .i_src_word(sw), .o_src_ready(sr),
      .o_snk_valid(kv), .o_snk_word(kw), .i_snk_ready(srdy));
   ibm_drive_model m0_u (.i_clk(clk), .i_en(en[0]), .i_ready(sr[0]),
      .o_valid(svld[0]), .o_word(sw[0]));
   ibm_drive_model m1_u (.i_clk(clk), .i_en(en[1]), .i_ready(sr[1]),
      .o_valid(svld[1]), .o_word(sw[1]));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // strobes last one cycle; pending event pulses drop as each strobe is raised
   task automatic wr_reg(logic [3:0] a, logic [7:0] d);
      @(negedge clk);
      {err, end_of_table_flag, addr, wdata, wr} = {4'h0, a, d, 1'b1};
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(logic [3:0] a, logic [7:0] e, string nm);
      @(negedge clk);
      {err, end_of_table_flag, addr, rd} = {4'h0, a, 1'b1};
      @(negedge clk);
      rd = 1'b0;
      chk(nm, e, rdata);
   endtask : rd_reg
   task automatic wait_pops(int k);
      for (int t = 0; t < 200 && pops < k; t++) @(negedge clk);
      if (pops < k) begin
         chk("pops", k, pops);
         end_sim();
      end
   endtask : wait_pops
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // every word reaching memory comes in order with none skipped
   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (kv[i] && srdy[i]) begin
            chk("word", ex[i], kw[i].data);
            ex[i] = ex[i] + 32'h0000_0001;
            pops += (i == 0);
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      foreach (ra[j]) rd_reg(ra[j], 8'h00, "reset");
      $display("test reset done");
      wr_reg(4'h2, 8'hE6);
      rd_reg(4'h2, 8'h60, "sts0");
      wr_reg(4'hA, 8'h20);
      rd_reg(4'hA, 8'h20, "sts1");
      wr_reg(4'h4, 8'hFF);
      rd_reg(4'h4, 8'h00, "unmapped");
      rd_reg(4'h2, 8'h60, "sts0b");
      $display("test status done");
      wr_reg(4'h0, 8'h09);
      chk("act", 2'b01, act);
      rd_reg(4'h0, 8'h09, "cmd");
      rd_reg(4'h2, 8'h61, "active");
      en[0] = 1'b1;
      wait_pops(4);
      srdy[0] = 1'b0;
      repeat (6) @(negedge clk);
      chk("stall", 4, pops);
      chk("full", 1'b0, sr[0]);
      srdy[0] = 1'b1;
      wait_pops(10);
      end_of_table_flag[0] = 1'b1;
      rd_reg(4'h2, 8'h60, "eot");
      rd_reg(4'h0, 8'h09, "cmd_eot");
      $display("test stream done");
      irq[0] = 1'b1;
      repeat (3) @(negedge clk);
      rd_reg(4'h2, 8'h64, "intr");
      wr_reg(4'h2, 8'h64);
      rd_reg(4'h2, 8'h60, "intr_clr");
      err[0] = 1'b1;
      rd_reg(4'h2, 8'h62, "err");
      wr_reg(4'h2, 8'h62);
      rd_reg(4'h2, 8'h60, "err_clr");
      irq[0] = 1'b0;
      $display("test events done");
      wr_reg(4'h8, 8'h01);
      en[1] = 1'b1;
      srdy[0] = 1'b0;
      repeat (4) @(negedge clk);
      wr_reg(4'h0, 8'h00);
      chk("stop", 3'b000, {start[0], act[0], kv[0]});
      ex[0] = m0_u.n;
      srdy[0] = 1'b1;
      repeat (2) @(negedge clk);
      chk("idle", 1'b0, sr[0]);
      wr_reg(4'h0, 8'h01);
      chk("dir", 1'b0, dir[0]);
      rd_reg(4'h2, 8'h61, "restart");
      wait_pops(pops + 3);
      end_of_table_flag[1] = 1'b1;
      wr_reg(4'h8, 8'h00);
      chk("ch1", 2'b00, {start[1], act[1]});
      $display("test stop done");
      end_sim();
   end
endmodule : ibm_ctrl_bench
